// File: core/tpic_pkg.sv
// Constants, types and register map of the timer pair with input capture
// Behaviour
// - Low run bit starts pair or low timer
// - Idle-stop bit halts timer in Idle
// - Gating only with internal clock source
// - Prescale 11/10/01/00 divides 256/64/8/1
// - Wide select joins timers into 32 bits
// - Low source: external pin rising or internal
// - High source: own pin or Fosc/2
// - Wide mode ignores high run/gate/prescale/source
// - Capture event latches selected 16-bit count
// - Timebase select: 1 low, 0 high
// - Interrupt every 1..4 captures per field
// - Overflow flag read-only, hardware cleared
// - Nonempty flag shows unread captured value
// - Four-entry FIFO read in arrival order
// - Mode selects edge, rising, falling, 4th, 16th
// - Mode 111 rising wake interrupt only
// - Modes 110 and 000 disable capture
// - Capture idle-stop halts channel in Idle
// - Capture pin event wakes from Sleep/Idle
// - Wide: low is lsw, high flag interrupts
// - High period msw, low period lsw
package tpic_pkg;
    // ==================================================
    // Register offsets (word index on the plain port)
    localparam logic [3:0] OFF_LO_CTL = 4'h0;
    localparam logic [3:0] OFF_HI_CTL = 4'h1;
    localparam logic [3:0] OFF_CAP_CTL = 4'h2;
    localparam logic [3:0] OFF_LO_CNT = 4'h3;
    localparam logic [3:0] OFF_HI_CNT = 4'h4;
    localparam logic [3:0] OFF_LO_PER = 4'h5;
    localparam logic [3:0] OFF_HI_PER = 4'h6;
    localparam logic [3:0] OFF_CAP_BUF = 4'h7;
    // ==================================================
    // Field positions
    localparam int RUN_B = 15;
    localparam int IDLE_B = 13;
    localparam int GATE_B = 6;
    localparam int PS_HI_B = 5;
    localparam int PS_LO_B = 4;
    localparam int WIDE_B = 3;
    localparam int SRC_B = 1;
    localparam int CAP_IDLE_B = 13;
    localparam int CAP_TMR_B = 7;
    localparam int CAP_PER_HI_B = 6;
    localparam int CAP_PER_LO_B = 5;
    localparam int CAP_OV_B = 4;
    localparam int CAP_NE_B = 3;
    // ==================================================
    // Writable bits and reset values
    localparam logic [15:0] LO_CTL_MASK = 16'ha07a;
    localparam logic [15:0] HI_CTL_MASK = 16'ha072;
    localparam logic [15:0] CAP_CTL_MASK = 16'h20e7;
    localparam logic [15:0] CTL_RST = 16'h0000;
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [15:0] PER_RST = 16'h0000;
    // ==================================================
    // Prescaler terminal counts
    localparam logic [7:0] PS_TERM_1 = 8'h00;
    localparam logic [7:0] PS_TERM_8 = 8'h07;
    localparam logic [7:0] PS_TERM_64 = 8'h3f;
    localparam logic [7:0] PS_TERM_256 = 8'hff;
    localparam logic [3:0] CAP_TERM_4 = 4'h3;
    localparam logic [3:0] CAP_TERM_16 = 4'hf;
    // ==================================================
    // Types
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tpic_bus_t;
    typedef enum logic [2:0] {
        CAP_OFF = 3'b000,
        CAP_BOTH = 3'b001,
        CAP_FALL = 3'b010,
        CAP_RISE = 3'b011,
        CAP_RISE4 = 3'b100,
        CAP_RISE16 = 3'b101,
        CAP_UNUSED = 3'b110,
        CAP_WAKE = 3'b111
    } tpic_cap_mode_t;
endpackage

// File: core/tpic_sync.sv
// Three-stage pin synchroniser with agreement filter
module tpic_sync #(
    parameter int W = 3
) (
    input wire logic clock, // Block clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic [W-1:0] async_in, // Raw pin levels
    output logic [W-1:0] level_q // Filtered levels
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] agree;

    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            level_q <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= (s3_q & agree) | (level_q & ~agree);
        end
    end
endmodule

// File: core/tpic_fifo.sv
// Small capture FIFO with registered read data
module tpic_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    input wire logic clock, // Block clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic wr_valid, // Push request
    input wire logic [W-1:0] wr_data, // Push data
    output logic wr_ready, // Space left
    input wire logic rd_ready, // Pop request
    output logic rd_valid, // Data waiting
    output logic [W-1:0] rd_data_q // Popped word
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    logic [W-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign wr_ready = cnt_q != (AW+1)'(DEPTH);
    assign rd_valid = cnt_q != '0;
    assign push = wr_valid && wr_ready;
    assign pop = rd_ready && rd_valid;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            rd_data_q <= '0;
        end else begin
            if (push) begin
                wp_q <= (wp_q == LAST) ? '0 : wp_q + 1'b1;
            end
            if (pop) begin
                rd_data_q <= mem_q[rp_q];
                rp_q <= (rp_q == LAST) ? '0 : rp_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// File: core/tpic_top.sv
// Timer pair with 32-bit chaining and one input capture channel
//
// The implementer's own choices: strobed register access and the address map.
module tpic_top (
    input wire logic clock, // Instruction clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire tpic_pkg::tpic_bus_t bus, // Register request
    output logic [15:0] rd_data, // Read data, cycle after rd
    input wire logic idle_mode, // Device in Idle
    input wire logic sleep_mode, // Device in Sleep
    input wire logic low_timer_ext_clock_pin, // Low clock/gate
    input wire logic high_timer_ext_clock_pin, // High clock/gate
    input wire logic capture_input_pin, // Capture input
    output logic low_period_irq, // Low period match pulse
    output logic high_period_irq, // High or wide match pulse
    output logic capture_irq, // Capture interrupt pulse
    output logic wake_req // Wake request pulse
);
    // ==================================================
    // Registers and decode
    logic [15:0] lo_ctl_q;
    logic [15:0] hi_ctl_q;
    logic [15:0] cap_ctl_q;
    logic [1:0][15:0] cnt_q;
    logic [1:0][15:0] per_q;
    logic [1:0] irq_q;
    logic wide;
    logic wr_lo_ctl;
    logic wr_lo_cnt;
    logic wr_hi_cnt;

    assign wide = lo_ctl_q[tpic_pkg::WIDE_B];
    assign wr_lo_ctl = bus.wr && bus.addr == tpic_pkg::OFF_LO_CTL;
    assign wr_lo_cnt = bus.wr && bus.addr == tpic_pkg::OFF_LO_CNT;
    assign wr_hi_cnt = bus.wr && bus.addr == tpic_pkg::OFF_HI_CNT;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            lo_ctl_q <= tpic_pkg::CTL_RST;
            hi_ctl_q <= tpic_pkg::CTL_RST;
            cap_ctl_q <= tpic_pkg::CTL_RST;
        end else if (bus.wr) begin
            case (bus.addr)
                tpic_pkg::OFF_LO_CTL: begin
                    lo_ctl_q <= bus.wdata & tpic_pkg::LO_CTL_MASK;
                end
                tpic_pkg::OFF_HI_CTL: begin
                    hi_ctl_q <= bus.wdata & tpic_pkg::HI_CTL_MASK;
                end
                tpic_pkg::OFF_CAP_CTL: begin
                    cap_ctl_q <= bus.wdata & tpic_pkg::CAP_CTL_MASK;
                end
                default: begin
                end
            endcase
        end
    end

    // Period halves; in wide mode high is msw, low is lsw
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            per_q <= {2{tpic_pkg::PER_RST}};
        end else if (bus.wr) begin
            if (bus.addr == tpic_pkg::OFF_LO_PER) begin
                per_q[0] <= bus.wdata;
            end
            if (bus.addr == tpic_pkg::OFF_HI_PER) begin
                per_q[1] <= bus.wdata;
            end
        end
    end

    // ==================================================
    // Pin synchronisers and edges
    logic [2:0] pin_s;
    logic [2:0] pin_prev_q;
    logic [2:0] rise;
    logic [2:0] fall;

    tpic_sync #(
        .W(3)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .async_in({capture_input_pin, high_timer_ext_clock_pin,
            low_timer_ext_clock_pin}),
        .level_q(pin_s)
    );

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            pin_prev_q <= '0;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    assign rise = pin_s & ~pin_prev_q;
    assign fall = ~pin_s & pin_prev_q;

    // ==================================================
    // Per-timer clock select, gate and prescaler
    logic [1:0] tick;

    for (genvar i = 0; i < 2; i++) begin : g_tmr
        logic [15:0] ctl;
        logic idle_stop;
        logic raw;
        logic halted;
        logic [7:0] term;
        logic [7:0] ps_q;

        assign ctl = (i == 0) ? lo_ctl_q : hi_ctl_q;
        // Wide pair also honours the high idle-stop bit
        assign idle_stop = ctl[tpic_pkg::IDLE_B]
            | (i == 0 && wide && hi_ctl_q[tpic_pkg::IDLE_B]);
        // External: pin rising edge; internal: every Fcy
        // cycle (Fosc/2), optionally gated by the pin level
        assign raw = ctl[tpic_pkg::SRC_B] ? rise[i]
            : (!ctl[tpic_pkg::GATE_B] || pin_s[i]);
        assign halted = !ctl[tpic_pkg::RUN_B]
            || (idle_mode && idle_stop)
            || (i == 1 && wide);

        always_comb begin
            case (ctl[tpic_pkg::PS_HI_B:tpic_pkg::PS_LO_B])
                2'b11: term = tpic_pkg::PS_TERM_256;
                2'b10: term = tpic_pkg::PS_TERM_64;
                2'b01: term = tpic_pkg::PS_TERM_8;
                default: term = tpic_pkg::PS_TERM_1;
            endcase
        end

        assign tick[i] = !halted && raw && ps_q >= term;

        always_ff @(posedge clock) begin
            if (!rst_b || !ctl[tpic_pkg::RUN_B]) begin
                ps_q <= '0;
            end else if (!halted && raw) begin
                ps_q <= (ps_q >= term) ? 8'h00 : ps_q + 8'h01;
            end
        end
    end

    // ==================================================
    // Counters and period match
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_q <= {2{tpic_pkg::CNT_RST}};
            irq_q <= '0;
        end else begin
            irq_q <= '0;
            if (wide) begin
                if (tick[0]) begin
                    if (cnt_q == per_q) begin
                        cnt_q <= '0;
                        irq_q[1] <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q + 32'h1;
                    end
                end
            end else begin
                for (int i = 0; i < 2; i++) begin
                    if (tick[i]) begin
                        if (cnt_q[i] == per_q[i]) begin
                            cnt_q[i] <= '0;
                            irq_q[i] <= 1'b1;
                        end else begin
                            cnt_q[i] <= cnt_q[i] + 16'h1;
                        end
                    end
                end
            end
            if (wr_lo_cnt) begin
                cnt_q[0] <= bus.wdata;
            end
            if (wr_hi_cnt) begin
                cnt_q[1] <= bus.wdata;
            end
        end
    end

    assign low_period_irq = irq_q[0];
    assign high_period_irq = irq_q[1];

    // ==================================================
    // Capture event selection
    tpic_pkg::tpic_cap_mode_t mode;
    logic cap_halt;
    logic low_power;
    logic cap_event;
    logic wake_evt;
    logic [3:0] cps_q;
    logic [3:0] cps_term;
    logic [1:0] per_cap;

    assign mode = tpic_pkg::tpic_cap_mode_t'(cap_ctl_q[2:0]);
    assign cap_halt = idle_mode && cap_ctl_q[tpic_pkg::CAP_IDLE_B];
    assign low_power = idle_mode || sleep_mode;
    assign per_cap =
        cap_ctl_q[tpic_pkg::CAP_PER_HI_B:tpic_pkg::CAP_PER_LO_B];
    assign cps_term = (mode == tpic_pkg::CAP_RISE16)
        ? tpic_pkg::CAP_TERM_16 : tpic_pkg::CAP_TERM_4;
    // Mode 111 only flags a rising edge while asleep or idle
    assign wake_evt = mode == tpic_pkg::CAP_WAKE
        && rise[2] && low_power;

    always_comb begin
        case (mode)
            tpic_pkg::CAP_BOTH: cap_event = rise[2] || fall[2];
            tpic_pkg::CAP_FALL: cap_event = fall[2];
            tpic_pkg::CAP_RISE: cap_event = rise[2];
            tpic_pkg::CAP_RISE4,
            tpic_pkg::CAP_RISE16: begin
                cap_event = rise[2] && cps_q == cps_term;
            end
            default: cap_event = 1'b0;
        endcase
        if (cap_halt) begin
            cap_event = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || (mode != tpic_pkg::CAP_RISE4
                && mode != tpic_pkg::CAP_RISE16)) begin
            cps_q <= '0;
        end else if (rise[2] && !cap_halt) begin
            cps_q <= (cps_q == cps_term) ? 4'h0 : cps_q + 4'h1;
        end
    end

    // ==================================================
    // Capture buffer, overflow and interrupt count
    logic fifo_ready;
    logic fifo_valid;
    logic [15:0] fifo_rdata;
    logic [15:0] cap_value;
    logic push;
    logic pop;
    logic ov_q;
    logic [1:0] ci_q;
    logic cap_irq_q;
    logic wake_q;

    assign cap_value = cap_ctl_q[tpic_pkg::CAP_TMR_B]
        ? cnt_q[0] : cnt_q[1];
    assign push = cap_event && fifo_ready;
    assign pop = bus.rd && bus.addr == tpic_pkg::OFF_CAP_BUF;

    tpic_fifo #(
        .W(16),
        .DEPTH(4)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .wr_valid(cap_event),
        .wr_data(cap_value),
        .wr_ready(fifo_ready),
        .rd_ready(pop),
        .rd_valid(fifo_valid),
        .rd_data_q(fifo_rdata)
    );

    // Set beats the hardware clear when the channel is turned off
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ov_q <= 1'b0;
        end else if (cap_event && !fifo_ready) begin
            ov_q <= 1'b1;
        end else if (mode == tpic_pkg::CAP_OFF) begin
            ov_q <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || mode == tpic_pkg::CAP_OFF) begin
            ci_q <= '0;
        end else if (push) begin
            ci_q <= (ci_q >= per_cap) ? 2'b00 : ci_q + 2'b01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cap_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            cap_irq_q <= (push && ci_q >= per_cap) || wake_evt;
            wake_q <= low_power && (cap_event || wake_evt);
        end
    end

    assign capture_irq = cap_irq_q;
    assign wake_req = wake_q;

    // ==================================================
    // Register read port
    logic [15:0] rd_q;
    logic pop_q;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rd_q <= '0;
            pop_q <= 1'b0;
        end else begin
            pop_q <= pop && fifo_valid;
            rd_q <= '0;
            if (bus.rd) begin
                case (bus.addr)
                    tpic_pkg::OFF_LO_CTL: rd_q <= lo_ctl_q;
                    tpic_pkg::OFF_HI_CTL: rd_q <= hi_ctl_q;
                    tpic_pkg::OFF_CAP_CTL: begin
                        rd_q <= cap_ctl_q;
                        rd_q[tpic_pkg::CAP_OV_B] <= ov_q;
                        rd_q[tpic_pkg::CAP_NE_B] <= fifo_valid;
                    end
                    tpic_pkg::OFF_LO_CNT: rd_q <= cnt_q[0];
                    tpic_pkg::OFF_HI_CNT: rd_q <= cnt_q[1];
                    tpic_pkg::OFF_LO_PER: rd_q <= per_q[0];
                    tpic_pkg::OFF_HI_PER: rd_q <= per_q[1];
                    default: rd_q <= '0;
                endcase
            end
        end
    end

    assign rd_data = pop_q ? fifo_rdata : rd_q;

    // ==================================================
    // Assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    property p_lo_stop;
        !lo_ctl_q[tpic_pkg::RUN_B] && !wr_lo_cnt |=> $stable(cnt_q[0]);
    endproperty
    a_lo_stop: assert property (p_lo_stop)
        else $error("low count moved while stopped");

    property p_idle_hold;
        idle_mode && lo_ctl_q[tpic_pkg::IDLE_B] |-> !tick[0];
    endproperty
    a_idle_hold: assert property (p_idle_hold)
        else $error("low timer ticked in idle");

    property p_ext_no_gate;
        lo_ctl_q[tpic_pkg::SRC_B] && !rise[0] |-> !tick[0];
    endproperty
    a_ext_no_gate: assert property (p_ext_no_gate)
        else $error("external timer ticked without edge");

    property p_ps8;
        (tick[0] && lo_ctl_q[5:4] == 2'b01)
        ##1 (!wr_lo_ctl && !tick[0]) [*6] ##1 !wr_lo_ctl |-> !tick[0];
    endproperty
    a_ps8: assert property (p_ps8)
        else $error("divide by 8 ticked early");

    property p_wide_carry;
        wide && tick[0] && cnt_q[0] == 16'hffff && cnt_q != per_q
        && !wr_lo_cnt && !wr_hi_cnt
        |=> cnt_q[1] == $past(cnt_q[1]) + 16'h1;
    endproperty
    a_wide_carry: assert property (p_wide_carry)
        else $error("no carry into high word");

    property p_hi_ignored;
        wide |-> !tick[1];
    endproperty
    a_hi_ignored: assert property (p_hi_ignored)
        else $error("high timer ran alone in wide mode");

    property p_wide_irq;
        wide ##1 wide |-> !irq_q[0];
    endproperty
    a_wide_irq: assert property (p_wide_irq)
        else $error("low flag raised in wide mode");

    property p_period_wrap;
        !wide && tick[0] && cnt_q[0] == per_q[0] && !wr_lo_cnt
        |=> cnt_q[0] == 16'h0000 && low_period_irq;
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("period match did not wrap");

    property p_off_no_cap;
        mode == tpic_pkg::CAP_OFF || mode == tpic_pkg::CAP_UNUSED
        |-> !cap_event;
    endproperty
    a_off_no_cap: assert property (p_off_no_cap)
        else $error("capture while disabled");

    property p_wake_only;
        mode == tpic_pkg::CAP_WAKE |-> !cap_event;
    endproperty
    a_wake_only: assert property (p_wake_only)
        else $error("capture in wake-only mode");

    property p_overflow;
        cap_event && !fifo_ready |=> ov_q;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("overflow not flagged");

    property p_nonempty;
        push |=> fifo_valid;
    endproperty
    a_nonempty: assert property (p_nonempty)
        else $error("buffer empty after capture");

    property p_every_cap;
        push && per_cap == 2'b00 |=> capture_irq;
    endproperty
    a_every_cap: assert property (p_every_cap)
        else $error("missing per-capture interrupt");

    property p_cap_halt;
        cap_halt |-> !cap_event;
    endproperty
    a_cap_halt: assert property (p_cap_halt)
        else $error("capture while halted in idle");

    property p_wake;
        low_power && cap_event |=> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake on capture event");
endmodule

// File: testbench/tpic_pins.sv
// Far-side pin model: capture input and external clock pins
module tpic_pins (
    input wire logic clock, // Block clock
    output logic low_clk, // Low timer external clock pin
    output logic high_clk, // High timer external clock pin
    output logic cap_pin // Capture input pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        low_clk = 1'b0;
        high_clk = 1'b0;
        cap_pin = 1'b0;
    end
    // Level change just after an edge, held until the next call
    task automatic drive_cap(input logic v);
        @(posedge clock);
        cap_pin <= v;
    endtask
endmodule

// File: testbench/timer_pair_input_capture_bench.sv
// Self-checking bench for the timer pair with input capture
module timer_pair_input_capture_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    tpic_pkg::tpic_bus_t bus = '0;
    logic [15:0] rd_data;
    logic lo_pin, hi_pin, cap_pin, lo_irq, hi_irq, cap_irq, wake;
    logic idle = 1'b0;
    logic sleep = 1'b0;
    int n_mismatch = 0;
    int checks_done = 0;
    always #4 clock = ~clock;
    tpic_pins pins_u (.clock(clock), .low_clk(lo_pin), .high_clk(hi_pin),
        .cap_pin(cap_pin));
    tpic_top dut_u (.clock(clock), .rst_b(rst_b), .bus(bus),
        .rd_data(rd_data), .idle_mode(idle), .sleep_mode(sleep),
        .low_timer_ext_clock_pin(lo_pin), .high_timer_ext_clock_pin(hi_pin),
        .capture_input_pin(cap_pin), .low_period_irq(lo_irq),
        .high_period_irq(hi_irq), .capture_irq(cap_irq), .wake_req(wake));
    // ==================================================
    // Bus and compare helpers
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clock);
        bus.rd <= 1'b0;
        #1 check(rd_data, exp);
    endtask
    task automatic wait_hi(ref logic s, output int n);
        n = 0;
        while (s !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
    endtask
    // One high then low level on the capture pin, high held 9 cycles, low held 8 cycles before return
    task automatic pulse();
        pins_u.drive_cap(1'b1);
        repeat (8) @(posedge clock);
        pins_u.drive_cap(1'b0);
        repeat (8) @(posedge clock);
    endtask
    // Cycles from one pulse of s to the next
    task automatic gap(ref logic s, output int n);
        wait_hi(s, n);
        @(posedge clock);
        #1;
        wait_hi(s, n);
        n++;
    endtask
    // ==================================================
    // Scenarios
    task automatic test_regs();
        rc(tpic_pkg::OFF_LO_CTL, 16'h0000);
        wr(tpic_pkg::OFF_LO_CTL, 16'hfff7);
        rc(tpic_pkg::OFF_LO_CTL, 16'ha072);
        wr(tpic_pkg::OFF_HI_CTL, 16'hffff);
        rc(tpic_pkg::OFF_HI_CTL, tpic_pkg::HI_CTL_MASK);
        wr(tpic_pkg::OFF_CAP_CTL, 16'hffff);
        rc(tpic_pkg::OFF_CAP_CTL, 16'h20e7);
        rc(4'hf, 16'h0000);
        wr(tpic_pkg::OFF_LO_CTL, 16'h0000);
        wr(tpic_pkg::OFF_HI_CTL, 16'h0000);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0000);
    endtask
    task automatic test_prescale();
        int n;
        int div [4] = '{1, 8, 64, 256};
        wr(tpic_pkg::OFF_LO_PER, 16'h0001);
        for (int p = 0; p < 4; p++) begin
            wr(tpic_pkg::OFF_LO_CTL, 16'h0000);
            wr(tpic_pkg::OFF_LO_CNT, 16'h0000);
            wr(tpic_pkg::OFF_LO_CTL, 16'h8000 | 16'(p << 4));
            gap(lo_irq, n);
            check(16'(n), 16'(2 * div[p]));
        end
        wr(tpic_pkg::OFF_LO_CTL, 16'h0000);
    endtask
    task automatic test_wide();
        int n;
        wr(tpic_pkg::OFF_HI_PER, 16'h0000);
        wr(tpic_pkg::OFF_LO_CNT, 16'h0000);
        wr(tpic_pkg::OFF_HI_CNT, 16'h0000);
        wr(tpic_pkg::OFF_HI_CTL, 16'h0032);
        wr(tpic_pkg::OFF_LO_CTL, 16'h8008);
        gap(hi_irq, n);
        check(16'(n), 16'h0002);
        wr(tpic_pkg::OFF_LO_CTL, 16'h0000);
        wr(tpic_pkg::OFF_HI_PER, 16'hffff);
        wr(tpic_pkg::OFF_HI_CTL, 16'h8000);
        wr(tpic_pkg::OFF_HI_CNT, 16'h0000);
        rc(tpic_pkg::OFF_HI_CNT, 16'h0001);
        wr(tpic_pkg::OFF_HI_CTL, 16'h0000);
    endtask
    task automatic test_modes();
        wr(tpic_pkg::OFF_LO_CNT, 16'h0055);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0082);
        pins_u.drive_cap(1'b1);
        repeat (8) @(posedge clock);
        rc(tpic_pkg::OFF_CAP_CTL, 16'h0082);
        pins_u.drive_cap(1'b0);
        repeat (8) @(posedge clock);
        rc(tpic_pkg::OFF_CAP_BUF, 16'h0055);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0084);
        repeat (3) pulse();
        rc(tpic_pkg::OFF_CAP_CTL, 16'h0084);
        pulse();
        rc(tpic_pkg::OFF_CAP_BUF, 16'h0055);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0000);
    endtask
    task automatic test_low_power();
        int n;
        wr(tpic_pkg::OFF_LO_PER, 16'hffff);
        @(posedge clock);
        idle <= 1'b1;
        wr(tpic_pkg::OFF_LO_CTL, 16'ha000);
        wr(tpic_pkg::OFF_LO_CNT, 16'h0012);
        rc(tpic_pkg::OFF_LO_CNT, 16'h0012);
        wr(tpic_pkg::OFF_LO_CTL, 16'h8000);
        wr(tpic_pkg::OFF_LO_CNT, 16'h0000);
        rc(tpic_pkg::OFF_LO_CNT, 16'h0001);
        wr(tpic_pkg::OFF_LO_CTL, 16'h0000);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h2003);
        pulse();
        rc(tpic_pkg::OFF_CAP_CTL, 16'h2003);
        @(posedge clock);
        idle <= 1'b0;
        sleep <= 1'b1;
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0007);
        pins_u.drive_cap(1'b1);
        wait_hi(wake, n);
        check(16'(n < 3000), 16'h0001);
        check({15'h0000, cap_irq}, 16'h0001);
        pins_u.drive_cap(1'b0);
        repeat (8) @(posedge clock);
        rc(tpic_pkg::OFF_CAP_CTL, 16'h0007);
        @(posedge clock);
        sleep <= 1'b0;
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0000);
    endtask
    task automatic test_capture();
        int n;
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0083);
        for (int i = 0; i < 5; i++) begin
            wr(tpic_pkg::OFF_LO_CNT, 16'h1000 + 16'(i));
            pins_u.drive_cap(1'b1);
            if (i < 4) begin
                wait_hi(cap_irq, n);
                check(16'(n < 3000), 16'h0001);
            end else begin
                repeat (12) @(posedge clock);
            end
            pins_u.drive_cap(1'b0);
            repeat (8) @(posedge clock);
        end
        rc(tpic_pkg::OFF_CAP_CTL, 16'h009b);
        for (int i = 0; i < 4; i++)
            rc(tpic_pkg::OFF_CAP_BUF, 16'h1000 + 16'(i));
        rc(tpic_pkg::OFF_CAP_CTL, 16'h0093);
        wr(tpic_pkg::OFF_CAP_CTL, 16'h0000);
        rc(tpic_pkg::OFF_CAP_CTL, 16'h0000);
    endtask
    // ==================================================
    // Verdict and run control
    task automatic close_out();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        test_regs();
        test_prescale();
        test_wide();
        test_capture();
        test_modes();
        test_low_power();
        close_out();
    end
    initial begin
        repeat (40000) @(posedge clock);
        n_mismatch++;
        close_out();
    end
endmodule
